/* sync_serial_status_reg.sv */
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module sync_serial_status_reg (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// axi4-lite write address and data
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// bus pins, sampled from outside the clock domain
	input wire logic sck_pin,
	input wire logic sda_pin,
	// events from the shifter and address logic
	input wire logic addr_match_pulse,
	input wire logic addr_rw_bit,
	input wire logic ack_pulse,
	input wire logic byte_done_pulse,
	input wire logic byte_is_data,
	input wire logic rx_complete_pulse,
	input wire logic buffer_read_pulse,
	input wire logic tx_load_pulse,
	input wire logic tx_done_pulse,
	input wire logic update_addr_pulse,
	input wire logic address_written_pulse,
	// strobes to the shifter and control levels
	output logic tx_change_strobe,
	output logic rx_sample_strobe,
	output logic serial_port_enable,
	output logic i2c_mode,
	output logic spi_master,
	output logic clock_idle_polarity,
	output logic ten_bit_addr,
	// interrupt
	output logic irq
);
	logic [7:0] status_ff;
	logic [serial_status_pkg::ctl_width-1:0] control_ff;
	logic [serial_status_pkg::irq_width-1:0] irq_status_ff;
	logic [serial_status_pkg::irq_width-1:0] irq_enable_ff;
	logic [serial_status_pkg::irq_width-1:0] irq_event;
	logic [serial_status_pkg::irq_width-1:0] irq_clear;
	logic [2:0] sck_sync_ff;
	logic [2:0] sda_sync_ff;
	logic sck_stable_ff;
	logic sda_stable_ff;
	logic sck_rise_ff;
	logic sck_fall_ff;
	logic sda_rise_ff;
	logic sda_fall_ff;
	logic scl_high_ff;
	logic start_seen;
	logic stop_seen;
	logic tx_on_rise;
	logic aw_held_ff;
	logic w_held_ff;
	logic [4:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic w_lane0_ff;
	logic do_write;
	logic wr_status;
	logic wr_control;
	logic wr_enable;
	logic wr_clear;
	logic wr_mapped;
	logic [31:0] nxt_rdata;
	logic nxt_rok;
	logic sample_phase;
	logic edge_select;

	assign serial_port_enable = control_ff[serial_status_pkg::ctl_enable_bit];
	assign i2c_mode = control_ff[serial_status_pkg::ctl_i2c_bit];
	assign spi_master = control_ff[serial_status_pkg::ctl_master_bit];
	assign clock_idle_polarity = control_ff[serial_status_pkg::ctl_polarity_bit];
	assign ten_bit_addr = control_ff[serial_status_pkg::ctl_ten_bit];
	assign sample_phase = status_ff[serial_status_pkg::sample_phase_bit];
	assign edge_select = status_ff[serial_status_pkg::edge_select_bit];

	// pin synchronisers: only the third stage is compared with the second
	always_ff @(posedge clk) begin
		if (reset) begin
			sck_sync_ff <= 3'h0;
			sda_sync_ff <= 3'h7;
		end else begin
			sck_sync_ff <= {sck_sync_ff[1:0], sck_pin};
			sda_sync_ff <= {sda_sync_ff[1:0], sda_pin};
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			sck_stable_ff <= 1'b0;
			sda_stable_ff <= 1'b1;
			sck_rise_ff <= 1'b0;
			sck_fall_ff <= 1'b0;
			sda_rise_ff <= 1'b0;
			sda_fall_ff <= 1'b0;
			scl_high_ff <= 1'b0;
		end else begin
			sck_rise_ff <= 1'b0;
			sck_fall_ff <= 1'b0;
			sda_rise_ff <= 1'b0;
			sda_fall_ff <= 1'b0;
			if (sck_sync_ff[1] == sck_sync_ff[2] && sck_sync_ff[2] != sck_stable_ff) begin
				sck_stable_ff <= sck_sync_ff[2];
				sck_rise_ff <= sck_sync_ff[2];
				sck_fall_ff <= ~sck_sync_ff[2];
			end
			if (sda_sync_ff[1] == sda_sync_ff[2] && sda_sync_ff[2] != sda_stable_ff) begin
				sda_stable_ff <= sda_sync_ff[2];
				sda_rise_ff <= sda_sync_ff[2];
				sda_fall_ff <= ~sda_sync_ff[2];
			end
			// scl level as seen before this sda edge, so a clock rise
			// in the same cycle does not fake a start or stop
			scl_high_ff <= sck_stable_ff;
		end
	end

	// transmit edge is rising exactly when edge-select and polarity differ
	assign tx_on_rise = edge_select ^ clock_idle_polarity;
	assign tx_change_strobe = serial_port_enable && !i2c_mode &&
		(tx_on_rise ? sck_rise_ff : sck_fall_ff);
	// end of output time is the next transmit edge, middle is the opposite edge;
	// sample phase is gated by spi_master here; both strobes are held off in i2c
	assign rx_sample_strobe = serial_port_enable && !i2c_mode &&
		((spi_master && sample_phase) ? (tx_on_rise ? sck_rise_ff : sck_fall_ff)
		: (tx_on_rise ? sck_fall_ff : sck_rise_ff));

	assign start_seen = serial_port_enable && i2c_mode && sda_fall_ff && scl_high_ff;
	assign stop_seen = serial_port_enable && i2c_mode && sda_rise_ff && scl_high_ff;

	// axi write: address and data are captured in either order
	assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
	assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
	assign do_write = aw_held_ff && w_held_ff;
	assign wr_status = do_write && w_lane0_ff && aw_addr_ff == serial_status_pkg::status_off;
	assign wr_control = do_write && w_lane0_ff && aw_addr_ff == serial_status_pkg::control_off;
	assign wr_enable = do_write && w_lane0_ff && aw_addr_ff == serial_status_pkg::irq_enable_off;
	assign wr_clear = do_write && w_lane0_ff && aw_addr_ff == serial_status_pkg::irq_clear_off;
	assign wr_mapped = aw_addr_ff == serial_status_pkg::status_off ||
		aw_addr_ff == serial_status_pkg::control_off ||
		aw_addr_ff == serial_status_pkg::irq_enable_off ||
		aw_addr_ff == serial_status_pkg::irq_clear_off;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held_ff <= 1'b0;
			w_held_ff <= 1'b0;
			aw_addr_ff <= 5'h00;
			w_data_ff <= 32'h0000_0000;
			w_lane0_ff <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= serial_status_pkg::resp_okay;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= {s_axi_awaddr[4:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_lane0_ff <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held_ff <= 1'b0;
				w_held_ff <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? serial_status_pkg::resp_okay
					: serial_status_pkg::resp_slverr;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi read
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rok = 1'b1;
		case ({s_axi_araddr[4:2], 2'h0})
			serial_status_pkg::status_off: nxt_rdata[7:0] = status_ff;
			serial_status_pkg::control_off: nxt_rdata[serial_status_pkg::ctl_width-1:0] = control_ff;
			serial_status_pkg::irq_status_off: nxt_rdata[serial_status_pkg::irq_width-1:0] = irq_status_ff;
			serial_status_pkg::irq_enable_off: nxt_rdata[serial_status_pkg::irq_width-1:0] = irq_enable_ff;
			serial_status_pkg::irq_clear_off: nxt_rdata = 32'h0000_0000;
			default: nxt_rok = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= serial_status_pkg::resp_okay;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= nxt_rdata;
			s_axi_rresp <= nxt_rok ? serial_status_pkg::resp_okay : serial_status_pkg::resp_slverr;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			control_ff <= '0;
		end else if (wr_control) begin
			control_ff <= w_data_ff[serial_status_pkg::ctl_width-1:0];
		end
	end

	// software-written phase bits
	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff[7:6] <= serial_status_pkg::status_reset[7:6];
		end else if (wr_status) begin
			status_ff[7:6] <= w_data_ff[7:6];
		end
	end

	// last byte kind
	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff[serial_status_pkg::data_addr_bit] <= 1'b0;
		end else if (i2c_mode && byte_done_pulse) begin
			status_ff[serial_status_pkg::data_addr_bit] <= byte_is_data;
		end
	end

	// start and stop: whichever came last; disable clears both
	always_ff @(posedge clk) begin
		if (reset || !serial_port_enable) begin
			status_ff[serial_status_pkg::stop_bit] <= 1'b0;
			status_ff[serial_status_pkg::start_bit] <= 1'b0;
		end else if (start_seen) begin
			status_ff[serial_status_pkg::start_bit] <= 1'b1;
			status_ff[serial_status_pkg::stop_bit] <= 1'b0;
		end else if (stop_seen) begin
			status_ff[serial_status_pkg::stop_bit] <= 1'b1;
			status_ff[serial_status_pkg::start_bit] <= 1'b0;
		end
	end

	// direction: a match in the same cycle as a terminator wins
	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff[serial_status_pkg::read_write_bit] <= 1'b0;
		end else if (i2c_mode && addr_match_pulse) begin
			status_ff[serial_status_pkg::read_write_bit] <= addr_rw_bit;
		end else if (start_seen || stop_seen || ack_pulse) begin
			status_ff[serial_status_pkg::read_write_bit] <= 1'b0;
		end
	end

	// update-address: set wins over the clear caused by the address write
	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff[serial_status_pkg::update_addr_bit] <= 1'b0;
		end else if (i2c_mode && ten_bit_addr && update_addr_pulse) begin
			status_ff[serial_status_pkg::update_addr_bit] <= 1'b1;
		end else if (address_written_pulse) begin
			status_ff[serial_status_pkg::update_addr_bit] <= 1'b0;
		end
	end

	// buffer full: filling wins over emptying in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			status_ff[serial_status_pkg::buffer_full_bit] <= 1'b0;
		end else if (rx_complete_pulse || (i2c_mode && tx_load_pulse)) begin
			status_ff[serial_status_pkg::buffer_full_bit] <= 1'b1;
		end else if (buffer_read_pulse || (i2c_mode && tx_done_pulse)) begin
			status_ff[serial_status_pkg::buffer_full_bit] <= 1'b0;
		end
	end

	// interrupts
	assign irq_event[serial_status_pkg::irq_start_bit] = start_seen;
	assign irq_event[serial_status_pkg::irq_stop_bit] = stop_seen;
	assign irq_event[serial_status_pkg::irq_full_bit] = rx_complete_pulse;
	assign irq_event[serial_status_pkg::irq_update_bit] = i2c_mode && ten_bit_addr && update_addr_pulse;
	assign irq_clear = wr_clear ? w_data_ff[serial_status_pkg::irq_width-1:0] : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_status_ff <= '0;
		end else begin
			irq_status_ff <= irq_event | (irq_status_ff & ~irq_clear);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_enable_ff <= '0;
		end else if (wr_enable) begin
			irq_enable_ff <= w_data_ff[serial_status_pkg::irq_width-1:0];
		end
	end

	assign irq = |(irq_status_ff & irq_enable_ff);
endmodule : sync_serial_status_reg

/* serial_status_pkg.sv */
// Overview of operation
// - as spi master, input is sampled at the end of the output time when the sample-phase bit is 1, else at its middle.
// - with idle polarity 0, edge-select 1 changes transmit data on rising sck, 0 on falling sck.
// - with idle polarity 1, edge-select 1 changes transmit data on falling sck, 0 on rising sck.
// - in i2c the stop and start flags show which condition came last, each clears the other, and both clear when disabled or reset.
// - in i2c the direction flag holds the read/write bit after the last address match, 1 read, until the next start, stop or ack.
// - in 10-bit i2c addressing the update-address flag is set when software must load the next address byte.
// - on receive the buffer-full flag is 1 once a byte is complete in the buffer and 0 while it is empty.
// - on i2c transmit the buffer-full flag is 1 while the buffer is occupied and 0 once transmission empties it.
package serial_status_pkg;
	localparam logic [4:0] status_off = 5'h00;
	localparam logic [4:0] control_off = 5'h04;
	localparam logic [4:0] irq_status_off = 5'h08;
	localparam logic [4:0] irq_enable_off = 5'h0c;
	localparam logic [4:0] irq_clear_off = 5'h10;
	localparam int sample_phase_bit = 7;
	localparam int edge_select_bit = 6;
	localparam int data_addr_bit = 5;
	localparam int stop_bit = 4;
	localparam int start_bit = 3;
	localparam int read_write_bit = 2;
	localparam int update_addr_bit = 1;
	localparam int buffer_full_bit = 0;
	localparam int ctl_enable_bit = 0;
	localparam int ctl_i2c_bit = 1;
	localparam int ctl_master_bit = 2;
	localparam int ctl_polarity_bit = 3;
	localparam int ctl_ten_bit = 4;
	localparam int ctl_width = 5;
	localparam int irq_start_bit = 0;
	localparam int irq_stop_bit = 1;
	localparam int irq_full_bit = 2;
	localparam int irq_update_bit = 3;
	localparam int irq_width = 4;
	localparam logic [7:0] status_reset = 8'h00;
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
endpackage : serial_status_pkg

/* serial_status_checker_assertions.sv */
`timescale 1ns/1ps
module serial_status_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// shifter strobes
	input wire logic tx_change_strobe,
	input wire logic rx_sample_strobe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	property p_b_answer;
		s_wr_both |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_b_answer: assert property (p_b_answer) else $error("write answer late");
	property p_b_once;
		s_b_done |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write answer repeated");
	property p_r_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_answer: assert property (p_r_answer) else $error("read answer late");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read answer repeated");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken while answering");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while answering");
	// one edge kind per sck period, so strobes never crowd
	property p_tx_once;
		tx_change_strobe |=> !tx_change_strobe [*5];
	endproperty
	a_tx_once: assert property (p_tx_once) else $error("tx strobe too long");
	property p_rx_once;
		rx_sample_strobe |=> !rx_sample_strobe [*5];
	endproperty
	a_rx_once: assert property (p_rx_once) else $error("rx strobe too long");
endmodule : serial_status_checker
bind sync_serial_status_reg serial_status_checker i_checker (
	.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .tx_change_strobe, .rx_sample_strobe
);

/* serial_bus_peer.sv */
`timescale 1ns/1ps
module serial_bus_peer (
	// core clock, only paces the pins
	input wire logic clk,
	// bus pins toward the port
	output logic sck_pin,
	output logic sda_pin
);
	initial begin
		sck_pin = 1'b0;
		sda_pin = 1'b1;
	end
	// offset of 7 ns keeps pin edges unrelated to the core clock
	task automatic drive(input logic c, input logic d);
		sck_pin <= #7 c;
		sda_pin <= #7 d;
		repeat (12) @(posedge clk);
	endtask : drive
	// 320 ns period, clock stands still after the frame
	task automatic burst(input int n);
		repeat (n) begin
			sck_pin <= #7 !sck_pin;
			repeat (4) @(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask : burst
endmodule : serial_bus_peer

/* sync_serial_status_reg_tb_top.sv */
`timescale 1ns/1ps
module sync_serial_status_reg_tb_top;
	logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, addr_rw_bit, byte_is_data;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0] s_axi_wstrb;
	logic [8:0] pl;
	wire s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	wire addr_match_pulse = pl[0], ack_pulse = pl[1], byte_done_pulse = pl[2];
	wire rx_complete_pulse = pl[3], buffer_read_pulse = pl[4], tx_load_pulse = pl[5];
	wire tx_done_pulse = pl[6], update_addr_pulse = pl[7], address_written_pulse = pl[8];
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sck_pin, sda_pin;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire tx_change_strobe, rx_sample_strobe, serial_port_enable, i2c_mode, spi_master;
	wire clock_idle_polarity, ten_bit_addr, irq;
	int mismatches = 0, checks = 0, cyc = 0, tx_n = 0, rx_n = 0;
	int st = 0, irqs = 0, sp = 0, e = 0, k, t0, r0;
	sync_serial_status_reg i_dut (.*);
	serial_bus_peer i_peer (.clk, .sck_pin, .sda_pin);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		tx_n <= tx_n + tx_change_strobe;
		rx_n <= rx_n + rx_sample_strobe;
		if (cyc == 30000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1,
			input logic [1:0] xr = serial_status_pkg::resp_okay);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", s_axi_bresp, xr);
	endtask : wr
	task automatic rc(input string n, input logic [4:0] a, input logic [31:0] x,
			input logic [1:0] xr = serial_status_pkg::resp_okay);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk(n, s_axi_rdata, x);
		chk({n, "_resp"}, s_axi_rresp, xr);
	endtask : rc
	initial begin
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, addr_rw_bit, byte_is_data} = 6'h20;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, pl} = '0;
		t0 = $urandom(32'h3fc5);
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		for (int a = 0; a <= 16; a += 4) rc("reset", a[4:0], 0);
		chk("irq", irq, 0);
		rc("unmapped", 5'h14, 0, serial_status_pkg::resp_slverr);
		wr(5'h14, 32'hff, 4'h1, serial_status_pkg::resp_slverr);
		wr(serial_status_pkg::status_off, 32'hc0, 4'h0);
		rc("strobe_off", serial_status_pkg::status_off, 0);
		$display("test bus done");
		for (int c = 0; c < 16; c++) begin
			sp = c[2] & c[3];
			e = c[0];
			wr(serial_status_pkg::control_off, 32'h1 | c[2] << 2 | c[1] << 3);
			chk("ctl_pins", {ten_bit_addr, clock_idle_polarity, spi_master, i2c_mode,
				serial_port_enable}, 32'h1 | c[2] << 2 | c[1] << 3);
			wr(serial_status_pkg::status_off, sp << 7 | e << 6 | $urandom_range(63));
			rc("status", serial_status_pkg::status_off, sp << 7 | e << 6 | st);
			i_peer.drive(c[1], 1'b1);
			t0 = tx_n;
			r0 = rx_n;
			i_peer.burst(16);
			chk("tx_burst", tx_n - t0, 8);
			chk("rx_burst", rx_n - r0, 8);
			t0 = tx_n;
			r0 = rx_n;
			i_peer.drive(!c[1], 1'b1);
			chk("tx_lead", tx_n - t0, e);
			chk("rx_lead", rx_n - r0, (c[2] && sp) ? e : !e);
		end
		$display("test spi done");
		// sample phase cleared before i2c use
		wr(serial_status_pkg::status_off, 0);
		wr(serial_status_pkg::control_off, 32'h13);
		chk("ctl_i2c", {ten_bit_addr, clock_idle_polarity, spi_master, i2c_mode,
			serial_port_enable}, 32'h13);
		rc("control", serial_status_pkg::control_off, 32'h13);
		for (int i = 0; i < 16; i++) begin
			t0 = $urandom_range(1);
			if (t0 == 1 && sck_pin === 1'b1) begin
				st[3] = sda_pin;
				st[4] = !sda_pin;
				st[2] = 1'b0;
				irqs |= sda_pin ? 1 : 2;
			end
			i_peer.drive(sck_pin ^ !t0[0], sda_pin ^ t0[0]);
			rc("start_stop", serial_status_pkg::status_off, st);
		end
		wr(serial_status_pkg::control_off, 32'h12);
		st[4:3] = 2'h0;
		rc("disabled", serial_status_pkg::status_off, st);
		wr(serial_status_pkg::control_off, 32'h13);
		$display("test i2c done");
		for (int i = 0; i < 40; i++) begin
			k = $urandom_range(8);
			t0 = $urandom_range(1);
			addr_rw_bit <= t0[0];
			byte_is_data <= t0[0];
			pl <= 9'h1 << k;
			@(posedge clk);
			pl <= 9'h0;
			case (k)
				0: st[2] = t0[0];
				1: st[2] = 1'b0;
				2: st[5] = t0[0];
				3, 5: st[0] = 1'b1;
				4, 6: st[0] = 1'b0;
				7: st[1] = 1'b1;
				default: st[1] = 1'b0;
			endcase
			irqs |= (k == 3) << 2 | (k == 7) << 3;
			rc("events", serial_status_pkg::status_off, st);
		end
		// spi mode without ten-bit: tx and update pulses are ignored, fill beats read
		wr(serial_status_pkg::control_off, 32'h1);
		pl <= 9'h118;
		@(posedge clk);
		pl <= 9'h0c0;
		@(posedge clk);
		pl <= 9'h0;
		st[1:0] = 2'h1;
		irqs |= 4;
		rc("gated", serial_status_pkg::status_off, st);
		rc("irq_status", serial_status_pkg::irq_status_off, irqs);
		wr(serial_status_pkg::irq_enable_off, 32'hf);
		rc("irq_enable", serial_status_pkg::irq_enable_off, 32'hf);
		chk("irq_on", irq, irqs != 0);
		wr(serial_status_pkg::irq_enable_off, 32'h0);
		chk("irq_masked", irq, 0);
		wr(serial_status_pkg::irq_clear_off, 32'hf);
		wr(serial_status_pkg::irq_enable_off, 32'hf);
		rc("irq_cleared", serial_status_pkg::irq_status_off, 0);
		chk("irq_off", irq, 0);
		$display("test events done");
		end_of_test();
	end
endmodule : sync_serial_status_reg_tb_top
